// [core/timer_channel_status_irq.v]
// Status, interrupt mask and capture/compare register view of one timer
// channel, with an AXI4-Lite slave. The counting datapath sits outside and
// supplies event pulses, capture values and line levels on clk.
// Overview of operation
// - Overflow sets status bit 0 until the next status read.
// - Capture mode: second unread capture load sets status bit 1.
// - Waveform mode: compare A match sets status bit 2.
// - Waveform mode: compare B match sets status bit 3.
// - Compare C match sets status bit 4 in either mode.
// - Capture mode: capture A load sets status bit 5.
// - Capture mode: capture B load sets status bit 6.
// - External trigger sets status bit 7.
// - Status bit 16 shows live counter clock enable, not read-cleared.
// - Status bit 17 mirrors line A: pin or driven level by mode.
// - Status bit 18 mirrors line B: pin or driven level by mode.
// - Ones written to enable register set mask bits.
// - Ones written to disable register clear mask bits.
// - Mask view register returns mask in status flag layout.
// - Compare C read returns its current value.
// - Capture A/B read-only in capture mode, writable in waveform.
`timescale 1ns/1ps
`include "tc_status_consts.vh"
module timer_channel_status_irq #(
  parameter VW = 16
) (
  input  wire          clk,             // 250 MHz peripheral clock
  input  wire          resetn,          // Async reset, active low
  input  wire [7:0]    s_axi_awaddr,    // Write address
  input  wire          s_axi_awvalid,   // Write address valid
  output wire          s_axi_awready,   // Write address ready
  input  wire [31:0]   s_axi_wdata,     // Write data
  input  wire [3:0]    s_axi_wstrb,     // Write byte strobes
  input  wire          s_axi_wvalid,    // Write data valid
  output wire          s_axi_wready,    // Write data ready
  output wire [1:0]    s_axi_bresp,     // Write response
  output wire          s_axi_bvalid,    // Write response valid
  input  wire          s_axi_bready,    // Write response ready
  input  wire [7:0]    s_axi_araddr,    // Read address
  input  wire          s_axi_arvalid,   // Read address valid
  output wire          s_axi_arready,   // Read address ready
  output wire [31:0]   s_axi_rdata,     // Read data
  output wire [1:0]    s_axi_rresp,     // Read response
  output wire          s_axi_rvalid,    // Read data valid
  input  wire          s_axi_rready,    // Read data ready
  input  wire          overflow_evt,    // Counter overflow pulse
  input  wire          match_a_evt,     // Compare A match pulse
  input  wire          match_b_evt,     // Compare B match pulse
  input  wire          match_c_evt,     // Compare C match pulse
  input  wire          load_a_evt,      // Capture A load pulse
  input  wire          load_b_evt,      // Capture B load pulse
  input  wire [VW-1:0] capture_a_in,    // Value captured on load A
  input  wire [VW-1:0] capture_b_in,    // Value captured on load B
  input  wire          ext_trigger_evt, // External trigger pulse
  input  wire          clock_on_state,  // Counter clock enabled level
  input  wire          channel_line_a,  // Sampled line A pin level
  input  wire          channel_line_b,  // Sampled line B pin level
  input  wire          drive_a,         // Level driven on line A
  input  wire          drive_b,         // Level driven on line B
  input  wire [VW-1:0] compare_c_live,  // Live compare C value
  output reg           wave_mode,       // 1 = output generation mode
  output reg  [VW-1:0] capture_compare_a, // Register A value
  output reg  [VW-1:0] capture_compare_b, // Register B value
  output wire          channel_irq      // Channel interrupt, active high
);
  reg          aw_got_q, w_got_q, bvalid_q, rvalid_q;
  reg  [7:0]   awaddr_q;
  reg  [31:0]  wdata_q;
  reg  [3:0]   wstrb_q;
  reg  [1:0]   bresp_q, rresp_q;
  reg  [31:0]  rdata_q;
  reg  [7:0]   mask_q;
  reg          unread_a_q, unread_b_q;
  wire [7:0]   flags;
  wire [7:0]   evt;
  wire         wr_fire, rd_fire, status_rd, rd_a, rd_b;
  reg  [31:0]  rd_mux;
  reg          rd_ok;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_CHANNEL_STATUS) || (a == `OFS_IRQ_ENABLE_SET) ||
                  (a == `OFS_IRQ_ENABLE_CLEAR) || (a == `OFS_IRQ_MASK_VIEW) ||
                  (a == `OFS_CAPTURE_A) || (a == `OFS_CAPTURE_B) ||
                  (a == `OFS_COMPARE_C) || (a == `OFS_CHANNEL_CTRL);
    end
  endfunction

  // Write channel: accept address and data in any order, answer when both
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bresp_q  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  wire wr_set  = wr_fire && awaddr_q == `OFS_IRQ_ENABLE_SET && wstrb_q[0];
  wire wr_clr  = wr_fire && awaddr_q == `OFS_IRQ_ENABLE_CLEAR && wstrb_q[0];
  wire wr_ctrl = wr_fire && awaddr_q == `OFS_CHANNEL_CTRL && wstrb_q[0];
  wire wr_a    = wr_fire && awaddr_q == `OFS_CAPTURE_A && wave_mode;
  wire wr_b    = wr_fire && awaddr_q == `OFS_CAPTURE_B && wave_mode;

  // Mask: only bits 7:0 are honoured, upper written bits dropped
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      mask_q <= `RST_MASK;
    else if (wr_set)
      mask_q <= mask_q | wdata_q[7:0];
    else if (wr_clr)
      mask_q <= mask_q & ~wdata_q[7:0];
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      wave_mode <= 1'b0;
    else if (wr_ctrl)
      wave_mode <= wdata_q[`BIT_WAVE_MODE];
  end

  // Capture registers: hardware loads in capture mode, software in waveform
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_compare_a <= `RST_VALUE16;
      capture_compare_b <= `RST_VALUE16;
    end else begin
      if (!wave_mode && load_a_evt)
        capture_compare_a <= capture_a_in;
      else if (wr_a && wstrb_q[1:0] == 2'h3)
        capture_compare_a <= wdata_q[VW-1:0];
      if (!wave_mode && load_b_evt)
        capture_compare_b <= capture_b_in;
      else if (wr_b && wstrb_q[1:0] == 2'h3)
        capture_compare_b <= wdata_q[VW-1:0];
    end
  end

  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_fire   = s_axi_arvalid && !rvalid_q;
  assign status_rd = rd_fire && s_axi_araddr == `OFS_CHANNEL_STATUS;
  assign rd_a      = rd_fire && s_axi_araddr == `OFS_CAPTURE_A;
  assign rd_b      = rd_fire && s_axi_araddr == `OFS_CAPTURE_B;

  // Overrun: a load while the previous one is still unread
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unread_a_q <= 1'b0;
      unread_b_q <= 1'b0;
    end else begin
      if (!wave_mode && load_a_evt)
        unread_a_q <= 1'b1;
      else if (rd_a)
        unread_a_q <= 1'b0;
      if (!wave_mode && load_b_evt)
        unread_b_q <= 1'b1;
      else if (rd_b)
        unread_b_q <= 1'b0;
    end
  end

  // Mode gating stops events of the other mode from setting their flags
  assign evt[`BIT_OVERFLOW]     = overflow_evt;
  assign evt[`BIT_LOAD_OVERRUN] = !wave_mode &&
      ((load_a_evt && unread_a_q) || (load_b_evt && unread_b_q));
  assign evt[`BIT_MATCH_A]      = wave_mode && match_a_evt;
  assign evt[`BIT_MATCH_B]      = wave_mode && match_b_evt;
  assign evt[`BIT_MATCH_C]      = match_c_evt;
  assign evt[`BIT_LOAD_A]       = !wave_mode && load_a_evt;
  assign evt[`BIT_LOAD_B]       = !wave_mode && load_b_evt;
  assign evt[`BIT_EXT_TRIGGER]  = ext_trigger_evt;

  // Flags of the old mode survive a mode switch until the next status read
  event_flag_bank #(.N(8)) u_flags (
    .clk       (clk),
    .resetn    (resetn),
    .set_pulse (evt),
    .clear_all (status_rd),
    .flags     (flags)
  );

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `OFS_CHANNEL_STATUS: begin
        rd_mux[7:0]          = flags;
        rd_mux[`BIT_CLOCK_ON] = clock_on_state;
        rd_mux[`BIT_LINE_A]  = wave_mode ? drive_a : channel_line_a;
        rd_mux[`BIT_LINE_B]  = wave_mode ? drive_b : channel_line_b;
      end
      `OFS_IRQ_MASK_VIEW:  rd_mux[7:0] = mask_q;
      `OFS_COMPARE_C:      rd_mux[VW-1:0] = compare_c_live;
      `OFS_CAPTURE_A:      rd_mux[VW-1:0] = capture_compare_a;
      `OFS_CAPTURE_B:      rd_mux[VW-1:0] = capture_compare_b;
      `OFS_CHANNEL_CTRL:   rd_mux[`BIT_WAVE_MODE] = wave_mode;
      `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_CLEAR: rd_mux = 32'h00000000;
      default:             rd_ok = 1'b0;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign channel_irq = |(flags & mask_q);
endmodule

// [core/tc_status_consts.vh]
// Register offsets, field positions and reset values of the timer channel
// status block. Definitions only.
`ifndef TC_STATUS_CONSTS_VH
`define TC_STATUS_CONSTS_VH
`define OFS_CHANNEL_STATUS   8'h20
`define OFS_IRQ_ENABLE_SET   8'h24
`define OFS_IRQ_ENABLE_CLEAR 8'h28
`define OFS_IRQ_MASK_VIEW    8'h2C
`define OFS_CAPTURE_A        8'h14
`define OFS_CAPTURE_B        8'h18
`define OFS_COMPARE_C        8'h1C
`define OFS_CHANNEL_CTRL     8'h04
`define BIT_OVERFLOW         0
`define BIT_LOAD_OVERRUN     1
`define BIT_MATCH_A          2
`define BIT_MATCH_B          3
`define BIT_MATCH_C          4
`define BIT_LOAD_A           5
`define BIT_LOAD_B           6
`define BIT_EXT_TRIGGER      7
`define BIT_CLOCK_ON         16
`define BIT_LINE_A           17
`define BIT_LINE_B           18
`define BIT_WAVE_MODE        0
`define RST_FLAGS            8'h00
`define RST_MASK             8'h00
`define RST_VALUE16          16'h0000
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// [core/event_flag_bank.v]
// Eight sticky event flags, set by hardware pulses, cleared on a status read.
// Assumes set and clear pulses are one clk cycle wide, synchronous to clk.
`timescale 1ns/1ps
module event_flag_bank #(
  parameter N = 8
) (
  input  wire         clk,       // Peripheral clock
  input  wire         resetn,    // Async reset, active low
  input  wire [N-1:0] set_pulse, // Per-flag event pulses
  input  wire         clear_all, // Status read in progress
  output wire [N-1:0] flags      // Sticky flags
);
  reg [N-1:0] flag_q;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      // Set beats clear so an event during the read is kept for next read
      always @(posedge clk or negedge resetn) begin
        if (!resetn)
          flag_q[i] <= 1'b0;
        else if (set_pulse[i])
          flag_q[i] <= 1'b1;
        else if (clear_all)
          flag_q[i] <= 1'b0;
      end
    end
  endgenerate
  assign flags = flag_q;
endmodule

// [verification/tc_status_props.sv]
// Checker for the timer channel block: bus handshakes and register updates.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module tc_status_props #(
  parameter VW = 16
) (
  input logic          clk,               // Clock
  input logic          resetn,            // Reset, active low
  input logic          s_axi_awvalid,     // AW valid
  input logic          s_axi_awready,     // AW ready
  input logic          s_axi_wvalid,      // W valid
  input logic          s_axi_wready,      // W ready
  input logic          s_axi_bvalid,      // B valid
  input logic          s_axi_bready,      // B ready
  input logic [1:0]    s_axi_bresp,       // B response
  input logic          s_axi_arvalid,     // AR valid
  input logic          s_axi_arready,     // AR ready
  input logic          s_axi_rvalid,      // R valid
  input logic          s_axi_rready,      // R ready
  input logic [31:0]   s_axi_rdata,       // R data
  input logic          load_a_evt,        // Capture A load
  input logic          wave_mode,         // Mode
  input logic [VW-1:0] capture_compare_a  // Register A
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
  a_write_answer: assert property (wr_taken |=> ##[0:1] s_axi_bvalid)
    else $error("write not answered");
  a_mode_by_write: assert property (!$stable(wave_mode) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("mode moved");
  a_cap_cause: assert property (!$stable(capture_compare_a) |->
    $past(load_a_evt) || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
    else $error("register A moved without cause");
endmodule
bind timer_channel_status_irq tc_status_props #(.VW(VW)) i_props (.clk,
  .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .load_a_evt,
  .wave_mode, .capture_compare_a);

// [verification/timer_channel_status_irq_tb.sv]
// Register-level bench for the timer channel status block over AXI4-Lite.
// Events are driven as one-cycle pulses; no datapath model is present.
`timescale 1ns/1ps
`include "tc_status_consts.vh"
module timer_channel_status_irq_tb;
  logic        clk = 0, resetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        overflow_evt = 0, match_a_evt = 0, match_b_evt = 0;
  logic        match_c_evt = 0, load_a_evt = 0, load_b_evt = 0;
  logic        ext_trigger_evt = 0, clock_on_state = 1;
  logic        channel_line_a = 1, channel_line_b = 0, drive_a = 0, drive_b = 1;
  logic [15:0] capture_a_in = 16'h1234, capture_b_in = 16'h4321;
  logic [15:0] compare_c_live = 16'hBEEF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, wave_mode, channel_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] capture_compare_a, capture_compare_b;
  int          n_mismatch = 0, num_checks = 0;
  timer_channel_status_irq #(.VW(16)) i_dut (.*);
  always #2 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic pa, pw, ga, gw;
    logic [1:0] r;
    pa = 1;
    pw = 1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (pa || pw) begin
      @(negedge clk);
      ga = s_axi_awready;
      gw = s_axi_wready;
      @(posedge clk);
      if (ga && pa) begin s_axi_awvalid <= 0; pa = 0; end
      if (gw && pw) begin s_axi_wvalid <= 0; pw = 0; end
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    // Late ready lets the checker see the response held while stalled
    @(posedge clk);
    s_axi_bready <= 1;
    @(negedge clk);
    r = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    @(posedge clk);
    s_axi_rready <= 1;
    @(negedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // Order: ext, load B, load A, match C, match B, match A, overflow
  task automatic pulse(input [6:0] v);
    @(posedge clk);
    {ext_trigger_evt, load_b_evt, load_a_evt, match_c_evt, match_b_evt,
     match_a_evt, overflow_evt} <= v;
    @(posedge clk);
    {ext_trigger_evt, load_b_evt, load_a_evt, match_c_evt, match_b_evt,
     match_a_evt, overflow_evt} <= 7'h00;
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    rd(`OFS_CHANNEL_STATUS, 32'h0003_0000, `RESP_OKAY);
    rd(`OFS_IRQ_MASK_VIEW, 32'h0, `RESP_OKAY);
    pulse(7'h7F);
    pulse(7'h10);
    rd(`OFS_CHANNEL_STATUS, 32'h0003_00F3, `RESP_OKAY);
    rd(`OFS_CHANNEL_STATUS, 32'h0003_0000, `RESP_OKAY);
    wr(`OFS_CAPTURE_A, 32'h0000_55AA, `RESP_OKAY);
    rd(`OFS_CAPTURE_A, 32'h0000_1234, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE_SET, 32'hFFFF_FF05, `RESP_OKAY);
    rd(`OFS_IRQ_MASK_VIEW, 32'h05, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE_CLEAR, 32'h0101, `RESP_OKAY);
    rd(`OFS_IRQ_MASK_VIEW, 32'h04, `RESP_OKAY);
    pulse(7'h08);
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, channel_irq});
    wr(`OFS_IRQ_ENABLE_SET, 32'h10, `RESP_OKAY);
    chk("irq", 32'h1, {31'h0, channel_irq});
    rd(`OFS_CHANNEL_STATUS, 32'h0003_0010, `RESP_OKAY);
    chk("irq", 32'h0, {31'h0, channel_irq});
    wr(`OFS_CHANNEL_CTRL, 32'h1, `RESP_OKAY);
    clock_on_state <= 0;
    pulse(7'h7F);
    rd(`OFS_CHANNEL_STATUS, 32'h0004_009D, `RESP_OKAY);
    rd(`OFS_COMPARE_C, 32'h0000_BEEF, `RESP_OKAY);
    wr(`OFS_CAPTURE_A, 32'h0000_55AA, `RESP_OKAY);
    rd(`OFS_CAPTURE_A, 32'h0000_55AA, `RESP_OKAY);
    rd(`OFS_IRQ_ENABLE_SET, 32'h0, `RESP_OKAY);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    wr(8'h44, 32'h1, `RESP_SLVERR);
    conclude();
  end
endmodule
